// ---- src/cfs_pkg.sv ----
// package for the serial command interpreter of the can adapter:
// command characters, status field positions, filter reset values.
// assumes ascii bytes from a serial receiver and a can core outside.
package cfs_pkg;
  localparam logic [7:0] CH_CR      = 8'h0D;
  localparam logic [7:0] CH_BELL    = 8'h07;
  localparam logic [7:0] CH_STAMP   = 8'h5A; // 'Z'
  localparam logic [7:0] CH_MASK    = 8'h6D; // 'm'
  localparam logic [7:0] CH_CODE    = 8'h4D; // 'M'
  localparam logic [7:0] CH_STATUS  = 8'h46; // status query
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_ONE     = 8'h31;
  localparam int         STD_DIGITS = 3;
  localparam int         EXT_DIGITS = 8;
  localparam int         MAX_ARGS   = 9;
  // status word field positions
  localparam int         ERR_LSB    = 0;
  localparam int         TX_OK_BIT  = 3;
  localparam int         RX_OK_BIT  = 4;
  localparam int         PASV_BIT   = 5;
  localparam int         WARN_BIT   = 6;
  localparam int         BOFF_BIT   = 7;
  localparam logic [2:0] ERR_BIT0   = 3'h5;
  localparam logic [2:0] ERR_UNUSED = 3'h7;
  localparam logic [2:0] ERR_STUFF  = 3'h1;
  localparam logic [2:0] ERR_BIT1   = 3'h4;
  // filter reset values
  localparam logic [10:0] STD_MASK_RST = 11'h000;
  localparam logic [28:0] EXT_MASK_RST = 29'h00000000;
  localparam logic [10:0] STD_CODE_RST = 11'h7FF;
  localparam logic [28:0] EXT_CODE_RST = 29'h01FFFFFF;
  localparam int         FIFO_DEPTH  = 32;
endpackage : cfs_pkg

// ---- src/cfs_fifo.sv ----
// synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  // full and empty come straight from the occupancy count
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem[rd_reg];

  // pointers and count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end
endmodule : cfs_fifo

// ---- src/cfs_cmd.sv ----
// serial command interpreter: timestamp on/off, acceptance mask and
// code, status query, receive filter feeding a frame-id fifo.
// assumes byte strobes from a uart and event pulses from a can core.
`timescale 1ns/10ps

// ----------------------------------------------------------------
// ----------------------------------------------------------------
module cfs_cmd #(
  parameter int DEPTH = cfs_pkg::FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // serial receive byte stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  // serial transmit byte stream
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic      [7:0]  o_tx_data,
  // channel state from the open/close logic
  input  wire logic        i_chan_open,
  // can core events and levels
  input  wire logic        i_frame_valid,
  input  wire logic        i_frame_ext,
  input  wire logic [28:0] i_frame_id,
  output logic             o_frame_ready,
  input  wire logic        i_err_valid,
  input  wire logic [2:0]  i_err_code,
  input  wire logic        i_boff_11rec,
  input  wire logic        i_tx_done,
  input  wire logic        i_rx_done,
  input  wire logic        i_err_passive,
  input  wire logic        i_err_warn,
  input  wire logic        i_bus_off,
  // software write of the status word
  input  wire logic        i_stat_wr,
  input  wire logic [7:0]  i_stat_wdata,
  // settings and filtered frames
  output logic             o_stamp_en,
  output logic      [7:0]  o_status,
  output logic             o_fwd_valid,
  input  wire logic        i_fwd_ready,
  output logic      [29:0] o_fwd_data
);
  // ----------------------------------------------------------------
  // command parser
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARGS = 3'b010,
    ST_SEND = 3'b100
  } cfs_state_e;

  cfs_state_e  st_reg;
  logic [7:0]  cmd_reg;
  logic [31:0] val_reg;
  logic [3:0]  nargs_reg;
  logic        bad_reg;
  logic [7:0]  resp_reg [3];
  logic [1:0]  rlen_reg;
  logic [1:0]  ridx_reg;
  logic        stamp_reg;
  logic [10:0] smask_reg;
  logic [28:0] emask_reg;
  logic [10:0] scode_reg;
  logic [28:0] ecode_reg;
  logic [2:0]  err_reg;
  logic        txok_reg;
  logic        rxok_reg;

  // hex digit decode, either letter case; bit 4 flags a valid digit
  function automatic logic [4:0] cfs_hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
    return 5'h00;
  endfunction : cfs_hex_val

  function automatic logic [7:0] cfs_hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? 8'(n) + 8'h30 : 8'(n) + 8'h37;
  endfunction : cfs_hex_chr

  // masked compare: only bits with mask one take part
  function automatic logic cfs_match(input logic [28:0] id,
                                     input logic [28:0] msk,
                                     input logic [28:0] code);
    return ((id ^ code) & msk) == 29'h00000000;
  endfunction : cfs_match

  wire [4:0] dig      = cfs_hex_val(i_rx_data);
  wire       is_cr    = (i_rx_data == cfs_pkg::CH_CR);
  wire       is_known = (i_rx_data == cfs_pkg::CH_STAMP) ||
                        (i_rx_data == cfs_pkg::CH_MASK) ||
                        (i_rx_data == cfs_pkg::CH_CODE) ||
                        (i_rx_data == cfs_pkg::CH_STATUS);
  wire       idle     = (st_reg == ST_IDLE);
  wire       args     = (st_reg == ST_ARGS);
  wire       fin      = args && i_rx_valid && is_cr;
  wire       is_std   = (nargs_reg == 4'(cfs_pkg::STD_DIGITS));
  wire       is_ext   = (nargs_reg == 4'(cfs_pkg::EXT_DIGITS));
  wire       len_ok   = is_std || is_ext;
  wire       is_stamp = (cmd_reg == cfs_pkg::CH_STAMP);
  wire       is_mask  = (cmd_reg == cfs_pkg::CH_MASK);
  wire       is_code  = (cmd_reg == cfs_pkg::CH_CODE);
  wire       is_stat  = (cmd_reg == cfs_pkg::CH_STATUS);
  wire       stamp_ok = is_stamp && !bad_reg && !i_chan_open &&
                        nargs_reg == 4'h1 && val_reg[31:1] == '0;
  // mask/code never touch the channel state: it simply stays as it was
  wire       filt_ok  = (is_mask || is_code) && !bad_reg && len_ok;
  wire       stat_ok  = is_stat && !bad_reg && nargs_reg == 4'h0;
  wire       cmd_ok   = stamp_ok || filt_ok || stat_ok;
  wire       tx_fire  = o_tx_valid && i_tx_ready;

  // parser sequencing; bytes arriving while a reply drains are dropped
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg    <= ST_IDLE;
      cmd_reg   <= 8'h00;
      val_reg   <= 32'h00000000;
      nargs_reg <= 4'h0;
      bad_reg   <= 1'b0;
      ridx_reg  <= 2'h0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (i_rx_valid) begin
            cmd_reg   <= i_rx_data;
            val_reg   <= 32'h00000000;
            nargs_reg <= 4'h0;
            bad_reg   <= !is_known;
            st_reg    <= is_cr ? ST_SEND : ST_ARGS;
            ridx_reg  <= 2'h0;
          end
        end
        ST_ARGS: begin
          if (i_rx_valid && is_cr) begin
            st_reg   <= ST_SEND;
            ridx_reg <= 2'h0;
          end else if (i_rx_valid) begin
            val_reg <= {val_reg[27:0], dig[3:0]};
            if (!dig[4] || nargs_reg == 4'(cfs_pkg::MAX_ARGS)) begin
              bad_reg <= 1'b1;
            end else begin
              nargs_reg <= nargs_reg + 4'h1;
            end
          end
        end
        ST_SEND: begin
          if (tx_fire) begin
            if (ridx_reg == rlen_reg) begin
              st_reg <= ST_IDLE;
            end
            // wrap to zero so the index never leaves the reply array
            ridx_reg <= (ridx_reg == rlen_reg) ? 2'h0 : ridx_reg + 2'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reply builder
  // ----------------------------------------------------------------
  // a bare CR outside a command is answered with BELL as malformed
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      resp_reg[0] <= 8'h00;
      resp_reg[1] <= 8'h00;
      resp_reg[2] <= 8'h00;
      rlen_reg    <= 2'h0;
    end else if (fin && stat_ok) begin
      resp_reg[0] <= cfs_hex_chr(o_status[7:4]);
      resp_reg[1] <= cfs_hex_chr(o_status[3:0]);
      resp_reg[2] <= cfs_pkg::CH_CR;
      rlen_reg    <= 2'h2;
    end else if (fin || (idle && i_rx_valid && is_cr)) begin
      resp_reg[0] <= (fin && cmd_ok) ? cfs_pkg::CH_CR
                                     : cfs_pkg::CH_BELL;
      rlen_reg    <= 2'h0;
    end
  end

  assign o_tx_valid = (st_reg == ST_SEND);
  assign o_tx_data  = resp_reg[ridx_reg];

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  // settings change only on a fully valid command
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stamp_reg <= 1'b0;
      smask_reg <= cfs_pkg::STD_MASK_RST;
      emask_reg <= cfs_pkg::EXT_MASK_RST;
      scode_reg <= cfs_pkg::STD_CODE_RST;
      ecode_reg <= cfs_pkg::EXT_CODE_RST;
    end else if (fin) begin
      if (stamp_ok) begin
        stamp_reg <= val_reg[0];
      end
      if (filt_ok && is_mask && is_std) begin
        smask_reg <= val_reg[10:0];
      end
      if (filt_ok && is_mask && is_ext) begin
        emask_reg <= val_reg[28:0];
      end
      if (filt_ok && is_code && is_std) begin
        scode_reg <= val_reg[10:0];
      end
      if (filt_ok && is_code && is_ext) begin
        ecode_reg <= val_reg[28:0];
      end
    end
  end

  assign o_stamp_en = stamp_reg;

  // ----------------------------------------------------------------
  // acceptance filter
  // ----------------------------------------------------------------
  // blocked frames are consumed at once; passing frames wait for room
  wire [28:0] f_mask = i_frame_ext ? emask_reg : {18'h0, smask_reg};
  wire [28:0] f_code = i_frame_ext ? ecode_reg : {18'h0, scode_reg};
  wire        f_pass = cfs_match(i_frame_id, f_mask, f_code);
  wire        q_ready;

  assign o_frame_ready = q_ready || !f_pass;

  cfs_fifo #(
    .WIDTH (30),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (i_frame_valid && f_pass),
    .o_in_ready  (q_ready),
    .i_in_data   ({i_frame_ext, i_frame_id}),
    .o_out_valid (o_fwd_valid),
    .i_out_ready (i_fwd_ready),
    .o_out_data  (o_fwd_data)
  );

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // bus events win over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      err_reg  <= cfs_pkg::ERR_UNUSED;
      txok_reg <= 1'b0;
      rxok_reg <= 1'b0;
    end else begin
      if (i_boff_11rec) begin
        err_reg <= cfs_pkg::ERR_BIT0;
      end else if (i_err_valid) begin
        err_reg <= i_err_code;
      end else if (i_stat_wr) begin
        err_reg <= i_stat_wdata[2:0];
      end
      if (i_tx_done) begin
        txok_reg <= 1'b1;
      end else if (i_stat_wr) begin
        txok_reg <= i_stat_wdata[cfs_pkg::TX_OK_BIT];
      end
      if (i_rx_done) begin
        rxok_reg <= 1'b1;
      end else if (i_stat_wr) begin
        rxok_reg <= i_stat_wdata[cfs_pkg::RX_OK_BIT];
      end
    end
  end

  // read-only state bits pass straight through from the core
  assign o_status = {i_bus_off,
                     i_err_warn,
                     i_err_passive,
                     rxok_reg, txok_reg, err_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_stamp_closed: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && is_stamp && i_chan_open |=> $stable(stamp_reg))
    else $error("timestamp changed while channel open");
  chk_stamp_set: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && stamp_ok |=> stamp_reg == $past(val_reg[0]))
    else $error("timestamp setting not applied");
  chk_mask_std: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && filt_ok && is_mask && is_std
    |=> smask_reg == $past(val_reg[10:0]))
    else $error("standard mask not stored");
  chk_mask_ext: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && filt_ok && is_mask && is_ext
    |=> emask_reg == $past(val_reg[28:0]))
    else $error("extended mask not stored");
  chk_code_std: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && filt_ok && is_code && is_std
    |=> scode_reg == $past(val_reg[10:0]))
    else $error("standard code not stored");
  chk_code_ext: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && filt_ok && is_code && is_ext
    |=> ecode_reg == $past(val_reg[28:0]))
    else $error("extended code not stored");
  chk_filter_block: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_frame_valid && ((i_frame_id ^ f_code) & f_mask) != '0
    |-> o_frame_ready && !u_fifo.push)
    else $error("mismatched frame entered queue");
  // a refused filter command must not leave a half-written setting
  chk_filt_keep: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && (is_mask || is_code) && !filt_ok |=> $stable(smask_reg) &&
    $stable(emask_reg) && $stable(scode_reg) && $stable(ecode_reg))
    else $error("filter setting changed by bad command");
  chk_bad_bell: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && !cmd_ok |=> o_tx_valid && o_tx_data == cfs_pkg::CH_BELL
    ##1 !o_tx_valid || !$past(i_tx_ready))
    else $error("malformed command not answered with bell");
  // a stalled consumer must see the same reply byte until it takes it
  chk_tx_hold: assert property (
    @(posedge i_clk) disable iff (i_srst)
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped before taken");
  chk_stat_reply: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fin && stat_ok |=> rlen_reg == 2'h2 &&
    resp_reg[2] == cfs_pkg::CH_CR)
    else $error("status reply malformed");
  chk_err_event: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_err_valid && !i_boff_11rec |=> err_reg == $past(i_err_code))
    else $error("error code event not loaded");
  chk_boff_code: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_boff_11rec |=> o_status[2:0] == cfs_pkg::ERR_BIT0)
    else $error("bus-off recovery code not loaded");
  chk_code_hold: assert property (
    @(posedge i_clk) disable iff (i_srst)
    err_reg == cfs_pkg::ERR_UNUSED && !i_err_valid && !i_boff_11rec &&
    !i_stat_wr |=> err_reg == cfs_pkg::ERR_UNUSED)
    else $error("unused code lost without event");
  chk_txok_sticky: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_tx_done |=> o_status[3] [*2] or
    (o_status[3] ##1 $past(i_stat_wr)))
    else $error("transmit ok flag not held");
  chk_rxok_set: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_rx_done |=> o_status[4])
    else $error("receive ok flag not set");
endmodule : cfs_cmd

// ---- tb/cfs_host.sv ----
// host model on the serial side: sends ascii command lines and
// collects the reply. assumes one byte per clock into the design.
`timescale 1ns/10ps
module cfs_host (
  input  wire logic       i_clk,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  // --------------------------------------------------------------
  // idle levels
  // --------------------------------------------------------------
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
  end

  // --------------------------------------------------------------
  // one command: bytes back to back, then take the reply
  // --------------------------------------------------------------
  // slow toggles ready, so each reply byte must stand until taken
  task automatic run(input string s, input bit slow, output string rsp,
                     output bit tmo);
    int n;
    rsp = "";
    for (n = 0; n < s.len(); n++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data  <= s[n];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~o_rx_data; // released byte no longer shows the last
    o_tx_ready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge i_clk);
      if (i_tx_valid === 1'b1 && o_tx_ready) begin
        rsp = {rsp, string'(i_tx_data)};
        if (i_tx_data == cfs_pkg::CH_CR || i_tx_data == cfs_pkg::CH_BELL)
          break;
      end
      o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end
    o_tx_ready <= 1'b0;
    tmo = (n == 400);
  endtask : run
endmodule : cfs_host

// ---- tb/can_filter_status_commands_test.sv ----
// self-checking bench for the serial command interpreter.
// assumes cfs_host as serial partner; can core events come from here.
`timescale 1ns/10ps
module can_filter_status_commands_test;
  // --------------------------------------------------------------
  // signals and bench state
  // --------------------------------------------------------------
  logic        clk, srst, rx_valid, tx_valid, tx_ready, chan_open;
  logic        fr_valid, fr_ext, fr_ready, err_valid, boff_11rec;
  logic        tx_done, rx_done, err_passive, err_warn, bus_off;
  logic        stat_wr, stamp_en, fwd_valid, fwd_ready;
  logic [7:0]  rx_data, tx_data, stat_wdata, status;
  logic [2:0]  err_code;
  logic [28:0] fr_id, fid, emask, ecode;
  logic [29:0] fwd_data;
  logic [29:0] expq[$];
  logic [10:0] smask, scode;
  logic [4:0]  st;
  logic [31:0] r;
  int          fails, checks, seed, fwd_mode, k;
  string       cr_s, bel_s, rsp;
  bit          tmo, took;

  cfs_cmd #(.DEPTH(32)) cfs_cmd_i (
    .i_clk(clk), .i_srst(srst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data),
    .i_chan_open(chan_open), .i_frame_valid(fr_valid), .i_frame_ext(fr_ext),
    .i_frame_id(fr_id), .o_frame_ready(fr_ready), .i_err_valid(err_valid),
    .i_err_code(err_code), .i_boff_11rec(boff_11rec), .i_tx_done(tx_done),
    .i_rx_done(rx_done), .i_err_passive(err_passive), .i_err_warn(err_warn),
    .i_bus_off(bus_off), .i_stat_wr(stat_wr), .i_stat_wdata(stat_wdata),
    .o_stamp_en(stamp_en), .o_status(status), .o_fwd_valid(fwd_valid),
    .i_fwd_ready(fwd_ready), .o_fwd_data(fwd_data));
  cfs_host cfs_host_i (
    .i_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // compare, report and expectation helpers
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cmd(input string c, input string exp);
    cfs_host_i.run({c, cr_s}, 1'($random(seed)), rsp, tmo);
    checks++;
    if (tmo || rsp != exp) begin
      fails++;
      $display("mismatch reply to %s expected %s seen %s", c, exp, rsp);
    end
    if (tmo) finish_test();
  endtask : cmd
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  // status word read both at the port and through the query
  task automatic st_check();
    logic [7:0] e;
    repeat (2) @(posedge clk);
    e = {bus_off, err_warn, err_passive, st};
    check("status word", 32'(e), 32'(status));
    cmd("F", {string'(hx(e[7:4])), string'(hx(e[3:0])), cr_s});
  endtask : st_check
  // one event cycle; bus events override a software write
  task automatic ev(input logic [4:0] v, input logic [2:0] lc,
                    input logic [7:0] wd);
    @(posedge clk);
    {err_valid, boff_11rec, tx_done, rx_done, stat_wr} <= v;
    err_code   <= lc;
    stat_wdata <= wd;
    @(posedge clk);
    {err_valid, boff_11rec, tx_done, rx_done, stat_wr} <= 5'h00;
    if (v[0]) st = wd[4:0];
    if (v[2]) st[3] = 1'b1;
    if (v[1]) st[4] = 1'b1;
    if (v[4]) st[2:0] = lc;
    if (v[3]) st[2:0] = 3'h5;
  endtask : ev
  function automatic bit passes(input logic e, input logic [28:0] id);
    if (e) return ((id ^ ecode) & emask) == 29'h0;
    return ((id[10:0] ^ scode) & smask) == 11'h0;
  endfunction : passes
  // offer a frame, hold it until taken or lim edges pass
  task automatic frame(input logic e, input logic [28:0] id, input int lim);
    int n;
    took = 1'b0;
    @(posedge clk);
    fr_valid <= 1'b1;
    fr_ext   <= e;
    fr_id    <= id;
    for (n = 0; n < lim && !took; n++) begin
      @(posedge clk);
      took = (fr_ready === 1'b1);
    end
    fr_valid <= 1'b0;
    fr_id    <= ~id;
    if (took && passes(e, id)) expq.push_back({e, id});
  endtask : frame
  task automatic drain();
    int n;
    for (n = 0; n < 3000 && expq.size() != 0; n++) @(posedge clk);
    check("queue drained", 32'h0, 32'(expq.size()));
    if (n == 3000) finish_test();
    repeat (3) @(posedge clk);
    check("fifo empty", 32'h0, 32'(fwd_valid));
  endtask : drain

  // forwarded frames come out in order; ready stalls at random
  always @(posedge clk) begin
    if (fwd_valid === 1'b1 && fwd_ready) begin
      check("forwarded frame", expq.size() ? 32'(expq[0]) : 32'hFFFFFFFF,
            32'(fwd_data));
      if (expq.size()) void'(expq.pop_front());
    end
    fwd_ready <= (fwd_mode == 2) ? 1'($random(seed)) : fwd_mode[0];
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 53019;
    fails = 0;
    checks = 0;
    fwd_mode = 0;
    cr_s = string'(cfs_pkg::CH_CR);
    bel_s = string'(cfs_pkg::CH_BELL);
    srst = 1'b1;
    chan_open = 1'b0;
    {fr_valid, fr_ext, fr_id, err_code, stat_wdata} = '0;
    {err_valid, boff_11rec, tx_done, rx_done, stat_wr} = 5'h00;
    {err_passive, err_warn, bus_off} = 3'h0;
    smask = cfs_pkg::STD_MASK_RST;
    scode = 11'h7FF;
    emask = 29'h00000000;
    ecode = 29'h01FFFFFF;
    st = 5'h07;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("stamp after reset", 32'h0, 32'(stamp_en));
    st_check();
    $display("test reset done");
    cmd("Z1", cr_s);
    check("stamp on", 32'h1, 32'(stamp_en));
    chan_open <= 1'b1;
    cmd("Z0", bel_s);
    check("stamp kept", 32'h1, 32'(stamp_en));
    chan_open <= 1'b0;
    cmd("Z0", cr_s);
    check("stamp off", 32'h0, 32'(stamp_en));
    cmd("Z2", bel_s);
    cmd("Z", bel_s);
    cmd("Q", bel_s);
    $display("test timestamp done");
    // default filter passes all; fill fifo until it refuses
    for (k = 0; k < 32; k++) begin
      r = $random(seed);
      frame(r[29], r[29] ? r[28:0] : {18'h0, r[10:0]}, 100);
      check("frame taken", 32'h1, 32'(took));
    end
    frame(1'b0, 29'h123, 8);
    check("full fifo refuses", 32'h0, 32'(took));
    fwd_mode = 2;
    drain();
    $display("test default filter done");
    // host sets the mask first, channel open to show it stays so
    chan_open <= 1'b1;
    cmd("m700", cr_s);
    smask = 11'h700;
    // code still at reset: only ids with bits 10..8 all ones may pass
    frame(1'b0, {18'h0, scode}, 300);
    frame(1'b0, 29'h0FF, 300);
    check("blocked frame taken", 32'h1, 32'(took));
    cmd("M1FF", cr_s);
    scode = 11'h1FF;
    r = $random(seed);
    emask = r[28:0];
    cmd($sformatf("m%08x", emask), cr_s);
    frame(1'b1, ecode, 300);
    r = $random(seed);
    ecode = r[28:0];
    cmd($sformatf("M%08X", ecode), cr_s);
    cmd("m12", bel_s);
    cmd("M1234", bel_s);
    chan_open <= 1'b0;
    for (k = 0; k < 60; k++) begin
      r = $random(seed);
      fid = r[29] ? r[28:0] : {18'h0, r[10:0]};
      if (r[30] && r[29]) fid = (fid & ~emask) | (ecode & emask);
      if (r[30] && !r[29]) fid[10:0] = (fid[10:0] & ~smask) | scode & smask;
      frame(r[29], fid, 300);
      check("frame taken", 32'h1, 32'(took));
    end
    drain();
    $display("test acceptance filter done");
    for (k = 0; k < 7; k++) begin
      ev(5'b10000, 3'(k), 8'h00);
      st_check();
    end
    ev(5'b01000, 3'h0, 8'h00);
    st_check();
    ev(5'b11000, 3'h2, 8'h00);
    st_check();
    ev(5'b00001, 3'h0, 8'h07);
    repeat (20) @(posedge clk);
    st_check();
    ev(5'b00100, 3'h0, 8'h00);
    st_check();
    ev(5'b00010, 3'h0, 8'h00);
    st_check();
    ev(5'b00001, 3'h0, 8'h1F);
    ev(5'b00001, 3'h0, 8'h07);
    st_check();
    ev(5'b10101, 3'h3, 8'h07);
    st_check();
    for (k = 0; k < 8; k++) begin
      {bus_off, err_warn, err_passive} <= 3'(k);
      st_check();
    end
    $display("test status done");
    finish_test();
  end
endmodule : can_filter_status_commands_test
